//--- inc/clk_pwr_pkg.sv
// Package: register map, field positions, reset values and states of the clock/power control
package clk_pwr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] clock_control_reg_a_off  = 8'h00;
  localparam logic [7:0] clock_control_reg_b_off  = 8'h04;
  localparam logic [7:0] clock_control_reg_c_off  = 8'h08;
  localparam logic [7:0] pll_control_reg_off      = 8'h0c;
  localparam logic [7:0] main_clock_divider_off   = 8'h10;
  localparam logic [7:0] processor_mode_reg_b_off = 8'h14;
  localparam logic [7:0] write_guard_reg_off      = 8'h18;
  localparam logic [7:0] mode_status_reg_off      = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // clock_control_reg_a
  localparam int wait_peripheral_halt_pos = 2;
  localparam int sub_osc_drive_pos        = 3;
  localparam int main_clock_halt_pos      = 5;
  localparam int sub_clock_select_pos     = 7;
  // clock_control_reg_b
  localparam int all_clocks_halt_pos      = 0;
  localparam int main_or_pll_select_pos   = 7;
  // clock_control_reg_c
  localparam int clock_source_select_pos  = 1;
  // pll_control_reg
  localparam int pll_power_pos            = 7;
  // processor_mode_reg_b
  localparam int wait_state_insert_pos    = 2;
  // write guard register
  localparam int write_guard_two_pos      = 2;
  // processor_mode_reg_b, write: enter wait mode
  localparam int wait_request_pos         = 7;
  // mode status bits
  localparam int stat_wait_pos            = 0;
  localparam int stat_stop_pos            = 1;
  localparam int stat_periph_gate_pos     = 2;
  localparam int stat_nmi_level_pos       = 3;
  localparam int stat_resume_pos          = 4;

  localparam int div_width = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] clock_control_reg_a_rst  = 8'h00;
  localparam logic [7:0] clock_control_reg_b_rst  = 8'h00;
  localparam logic [7:0] clock_control_reg_c_rst  = 8'h00;
  localparam logic [7:0] pll_control_reg_rst      = 8'h00;
  localparam logic [4:0] main_clock_divider_rst   = 5'h08;
  localparam logic [7:0] processor_mode_reg_b_rst = 8'h00;

  // Cycles the prefetched instruction takes to retire on stop exit
  localparam logic [1:0] prefetch_drain_cycles    = 2'h2;

  typedef enum logic [1:0] {
    pwr_run,
    pwr_wait,
    pwr_stop,
    pwr_drain
  } pwr_state_e;

endpackage : clk_pwr_pkg

//--- rtl/apb_reg_slave.sv
// APB slave front end: decodes one transfer into write and read strobes
`timescale 1ns/100ps
module apb_reg_slave (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       acc_addr
);

  logic ready_reg;
  logic ready_next;

  // ----------------------------------------------------------------
  // One wait state: ready rises in the second access cycle
  // ----------------------------------------------------------------
  always_comb begin
    ready_next = psel && penable && !ready_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  assign pready   = ready_reg;
  assign pslverr  = 1'b0;
  assign wr_stb   = ready_reg && psel && penable && pwrite;
  assign rd_stb   = ready_next && !pwrite;
  assign acc_addr = paddr;

endmodule : apb_reg_slave

//--- rtl/clk_divider.sv
// Clock enable generator: one pulse every (divide value) cycles, zero meaning 16
`timescale 1ns/100ps
module clk_divider (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [4:0] div_val,
  output logic            tick
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;
  logic [4:0] limit;

  always_comb begin
    limit     = (div_val == 5'h00) ? 5'h0f : div_val - 5'h01;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (run) begin
      if (cnt_reg >= limit) begin
        cnt_next  = 5'h00;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : clk_divider

//--- rtl/clock_power_mode_control.sv
// Clock source selection, division, wait/stop control and write guard
//
// Behaviour
// RQ1: Software never halts the main clock while an external clock feeds the CPU.
// RQ2: Software keeps wait-state bit zero while changing the main clock divider.
// RQ3: Software sets divider for CPU clock at most 10 MHz before gated wait.
// RQ4: Software clears main/PLL, source and sub select bits before stop entry.
// RQ5: Software selects main clock and powers PLL off before stop entry.
// RQ6: Stop entry is refused while the NMI pin is low.
// RQ7: Reset is held low until main oscillation is stable after stop.
// RQ8: NMI stop exit, then dummy interrupt, then set all-clocks-halt bit.
// RQ9: On stop exit the prefetched instruction retires before the recovery routine.
// RQ10: Software follows the stop instruction with short jump and no-ops.
// RQ11: Software follows the wait instruction with at least four no-ops.
// RQ12: Gated wait stops peripheral clocks but keeps the sub-derived clock running.
// RQ13: Software avoids gated wait in low-speed or low-power mode.
// RQ14: Write guard bit two clears itself on the next write to any address.
// RQ15: Software lets no interrupt or DMA occur between guard set and write.
// RQ16: Software waits for a clock to stabilise before selecting it.
// RQ17: The external clock keeps running while it is the selected CPU clock.
// RQ18: Stop entry forces the sub-oscillator drive bit to one.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module clock_power_mode_control (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nmi_n,
  input  wire logic        any_write,
  output logic             main_clk_run,
  output logic             sub_clk_select,
  output logic             pll_clk_select,
  output logic             pll_enable,
  output logic             sub_osc_high_drive,
  output logic             cpu_clk_tick,
  output logic             cpu_run,
  output logic             periph_clk_run,
  output logic             sub_periph_clk_run,
  output logic             wait_state_on,
  output logic             recovery_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  cca_reg;
  logic [7:0]  cca_next;
  logic [7:0]  ccb_reg;
  logic [7:0]  ccb_next;
  logic [7:0]  ccc_reg;
  logic [7:0]  ccc_next;
  logic [7:0]  pll_reg;
  logic [7:0]  pll_next;
  logic [4:0]  div_reg;
  logic [4:0]  div_next;
  logic [7:0]  pmb_reg;
  logic [7:0]  pmb_next;
  logic        guard_reg;
  logic        guard_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  clk_pwr_pkg::pwr_state_e state_reg;
  clk_pwr_pkg::pwr_state_e state_next;
  logic [1:0]  drain_reg;
  logic [1:0]  drain_next;
  logic        irq_reg;
  logic        irq_next;

  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  acc_addr;
  logic        div_tick;

  logic        stop_req;
  logic        wait_req;

  // ----------------------------------------------------------------
  // Bus front end and divider
  // ----------------------------------------------------------------
  apb_reg_slave apb_reg_slave_i (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .acc_addr (acc_addr)
  );

  clk_divider clk_divider_i (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state_reg == clk_pwr_pkg::pwr_run),
    .div_val (div_reg),
    .tick    (div_tick)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    cca_next = cca_reg;
    ccb_next = ccb_reg;
    ccc_next = ccc_reg;
    pll_next = pll_reg;
    div_next = div_reg;
    pmb_next = pmb_reg;
    guard_next = guard_reg;
    stop_req = 1'b0;
    wait_req = 1'b0;
    // Any write anywhere consumes the guard; a new set in the same write wins
    if (any_write || wr_stb) begin
      guard_next = 1'b0; // [RQ14]
    end
    if (wr_stb) begin
      case (acc_addr)
        clk_pwr_pkg::clock_control_reg_a_off: begin
          cca_next = pwdata[7:0];
        end
        clk_pwr_pkg::clock_control_reg_b_off: begin
          ccb_next = pwdata[7:0];
          ccb_next[clk_pwr_pkg::all_clocks_halt_pos] = 1'b0;
          stop_req = pwdata[clk_pwr_pkg::all_clocks_halt_pos];
        end
        clk_pwr_pkg::clock_control_reg_c_off: begin
          ccc_next = pwdata[7:0];
        end
        clk_pwr_pkg::pll_control_reg_off: begin
          // PLL settings only change while the guard is open
          if (guard_reg) begin
            pll_next = pwdata[7:0];
          end
        end
        clk_pwr_pkg::main_clock_divider_off: begin
          div_next = pwdata[4:0];
        end
        clk_pwr_pkg::processor_mode_reg_b_off: begin
          pmb_next = pwdata[7:0];
          pmb_next[clk_pwr_pkg::wait_request_pos] = 1'b0;
          wait_req = pwdata[clk_pwr_pkg::wait_request_pos];
        end
        clk_pwr_pkg::write_guard_reg_off: begin
          if (pwdata[clk_pwr_pkg::write_guard_two_pos]) begin
            guard_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Drive forced high on stop entry so the sub crystal restarts reliably
    if (stop_req && nmi_n) begin
      cca_next[clk_pwr_pkg::sub_osc_drive_pos] = 1'b1; // [RQ18]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cca_reg   <= clk_pwr_pkg::clock_control_reg_a_rst;
      ccb_reg   <= clk_pwr_pkg::clock_control_reg_b_rst;
      ccc_reg   <= clk_pwr_pkg::clock_control_reg_c_rst;
      pll_reg   <= clk_pwr_pkg::pll_control_reg_rst;
      div_reg   <= clk_pwr_pkg::main_clock_divider_rst;
      pmb_reg   <= clk_pwr_pkg::processor_mode_reg_b_rst;
      guard_reg <= 1'b0;
    end else begin
      cca_reg   <= cca_next;
      ccb_reg   <= ccb_next;
      ccc_reg   <= ccc_next;
      pll_reg   <= pll_next;
      div_reg   <= div_next;
      pmb_reg   <= pmb_next;
      guard_reg <= guard_next;
    end
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    drain_next = drain_reg;
    irq_next   = 1'b0;
    case (state_reg)
      clk_pwr_pkg::pwr_run: begin
        if (stop_req && nmi_n) begin
          state_next = clk_pwr_pkg::pwr_stop; // [RQ6]
        end else if (wait_req) begin
          state_next = clk_pwr_pkg::pwr_wait;
        end
      end
      clk_pwr_pkg::pwr_wait: begin
        // Only NMI or reset resumes; no other wakeup source is modelled
        if (!nmi_n) begin
          state_next = clk_pwr_pkg::pwr_run;
          irq_next   = 1'b1;
        end
      end
      clk_pwr_pkg::pwr_stop: begin
        if (!nmi_n) begin
          state_next = clk_pwr_pkg::pwr_drain;
          drain_next = clk_pwr_pkg::prefetch_drain_cycles;
        end
      end
      clk_pwr_pkg::pwr_drain: begin
        // Queued instruction retires before the recovery request
        if (drain_reg == 2'h1) begin
          state_next = clk_pwr_pkg::pwr_run; // [RQ9]
          irq_next   = 1'b1;
        end
        drain_next = drain_reg - 2'h1;
      end
      default: begin
        state_next = clk_pwr_pkg::pwr_run;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= clk_pwr_pkg::pwr_run;
      drain_reg <= 2'h0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      drain_reg <= drain_next;
      irq_reg   <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_stb) begin
      rdata_next = 32'h0000_0000;
      case (acc_addr)
        clk_pwr_pkg::clock_control_reg_a_off:  rdata_next[7:0] = cca_reg;
        clk_pwr_pkg::clock_control_reg_b_off:  rdata_next[7:0] = ccb_reg;
        clk_pwr_pkg::clock_control_reg_c_off:  rdata_next[7:0] = ccc_reg;
        clk_pwr_pkg::pll_control_reg_off:      rdata_next[7:0] = pll_reg;
        clk_pwr_pkg::main_clock_divider_off:   rdata_next[4:0] = div_reg;
        clk_pwr_pkg::processor_mode_reg_b_off: rdata_next[7:0] = pmb_reg;
        clk_pwr_pkg::write_guard_reg_off: begin
          rdata_next[clk_pwr_pkg::write_guard_two_pos] = guard_reg;
        end
        clk_pwr_pkg::mode_status_reg_off: begin
          rdata_next[clk_pwr_pkg::stat_wait_pos] = (state_reg == clk_pwr_pkg::pwr_wait);
          rdata_next[clk_pwr_pkg::stat_stop_pos] = (state_reg == clk_pwr_pkg::pwr_stop);
          rdata_next[clk_pwr_pkg::stat_periph_gate_pos] = !periph_clk_run;
          rdata_next[clk_pwr_pkg::stat_nmi_level_pos] = nmi_n;
          rdata_next[clk_pwr_pkg::stat_resume_pos] = (state_reg == clk_pwr_pkg::pwr_drain);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock control outputs, all registered
  // ----------------------------------------------------------------
  logic out_main_reg;
  logic out_sub_reg;
  logic out_pll_sel_reg;
  logic out_pll_en_reg;
  logic out_drive_reg;
  logic out_cpu_reg;
  logic out_periph_reg;
  logic out_sub_periph_reg;
  logic out_ws_reg;
  logic out_tick_reg;
  logic gated_wait;
  logic stopped;

  always_comb begin
    stopped    = (state_reg == clk_pwr_pkg::pwr_stop);
    gated_wait = (state_reg == clk_pwr_pkg::pwr_wait)
                 && cca_reg[clk_pwr_pkg::wait_peripheral_halt_pos];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_main_reg       <= 1'b1;
      out_sub_reg        <= 1'b0;
      out_pll_sel_reg    <= 1'b0;
      out_pll_en_reg     <= 1'b0;
      out_drive_reg      <= 1'b0;
      out_cpu_reg        <= 1'b1;
      out_periph_reg     <= 1'b1;
      out_sub_periph_reg <= 1'b1;
      out_ws_reg         <= 1'b0;
      out_tick_reg       <= 1'b0;
    end else begin
      out_main_reg       <= !stopped && !cca_reg[clk_pwr_pkg::main_clock_halt_pos];
      out_sub_reg        <= cca_reg[clk_pwr_pkg::sub_clock_select_pos];
      out_pll_sel_reg    <= ccb_reg[clk_pwr_pkg::main_or_pll_select_pos]
                            && !ccc_reg[clk_pwr_pkg::clock_source_select_pos];
      out_pll_en_reg     <= !stopped && pll_reg[clk_pwr_pkg::pll_power_pos];
      out_drive_reg      <= cca_reg[clk_pwr_pkg::sub_osc_drive_pos];
      out_cpu_reg        <= (state_reg == clk_pwr_pkg::pwr_run)
                            || (state_reg == clk_pwr_pkg::pwr_drain);
      out_periph_reg     <= !stopped && !gated_wait;
      out_sub_periph_reg <= !stopped; // [RQ12]
      out_ws_reg         <= pmb_reg[clk_pwr_pkg::wait_state_insert_pos];
      out_tick_reg       <= div_tick;
    end
  end

  assign prdata             = rdata_reg;
  assign main_clk_run       = out_main_reg;
  assign sub_clk_select     = out_sub_reg;
  assign pll_clk_select     = out_pll_sel_reg;
  assign pll_enable         = out_pll_en_reg;
  assign sub_osc_high_drive = out_drive_reg;
  assign cpu_clk_tick       = out_tick_reg;
  assign cpu_run            = out_cpu_reg;
  assign periph_clk_run     = out_periph_reg;
  assign sub_periph_clk_run = out_sub_periph_reg;
  assign wait_state_on      = out_ws_reg;
  assign recovery_irq       = irq_reg;

endmodule : clock_power_mode_control

//--- test/clock_power_mode_control_sva.sv
// Port-level assertions for the clock, power mode and write guard block
`timescale 1ns/100ps
module clock_power_mode_control_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        nmi_n,
  input wire logic        main_clk_run,
  input wire logic        pll_enable,
  input wire logic        sub_osc_high_drive,
  input wire logic        cpu_run,
  input wire logic        periph_clk_run,
  input wire logic        sub_periph_clk_run,
  input wire logic        recovery_irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic stop_req;
  assign stop_req = psel && penable && pready && pwrite
                    && pwdata[clk_pwr_pkg::all_clocks_halt_pos]
                    && paddr == clk_pwr_pkg::clock_control_reg_b_off;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  stop_refuse_a: assert property (stop_req && !nmi_n && cpu_run |=> cpu_run[*3])
    else $error("stop entered while nmi pin low");
  stop_enter_a: assert property (
    stop_req && nmi_n && cpu_run && sub_periph_clk_run |-> ##[1:3] (!cpu_run && !main_clk_run))
    else $error("stop not entered with nmi pin high");
  drive_on_stop_a: assert property ($fell(sub_periph_clk_run) |-> sub_osc_high_drive)
    else $error("sub oscillator drive not high in stop");
  sub_clk_keep_a: assert property (periph_clk_run |-> sub_periph_clk_run)
    else $error("sub derived clock stopped while peripherals run");
  drain_first_a: assert property (
    $rose(sub_periph_clk_run) |-> cpu_run && !recovery_irq ##1 recovery_irq)
    else $error("recovery routine before queued instruction");
  stop_gate_a: assert property (
    !sub_periph_clk_run |-> !pll_enable && !main_clk_run && !periph_clk_run)
    else $error("clock left running in stop");
  pready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("bus answer not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("bus ready held too long");

  cover property ($fell(sub_periph_clk_run));
  cover property (!periph_clk_run && sub_periph_clk_run);
  cover property (recovery_irq);
endmodule : clock_power_mode_control_sva

//--- test/test_clock_power_mode_control.sv
// Self-checking testbench for the clock, power mode and write guard block
`timescale 1ns/100ps
module test_clock_power_mode_control;
  localparam logic [7:0] cca = clk_pwr_pkg::clock_control_reg_a_off;
  localparam logic [7:0] ccb = clk_pwr_pkg::clock_control_reg_b_off;
  localparam logic [7:0] ccc = clk_pwr_pkg::clock_control_reg_c_off;
  localparam logic [7:0] plr = clk_pwr_pkg::pll_control_reg_off;
  localparam logic [7:0] dvr = clk_pwr_pkg::main_clock_divider_off;
  localparam logic [7:0] pmb = clk_pwr_pkg::processor_mode_reg_b_off;
  localparam logic [7:0] grd = clk_pwr_pkg::write_guard_reg_off;

  logic        clk_sys, rst_n, psel, penable, pwrite, nmi_n, any_write;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, main_clk_run, sub_clk_select, pll_clk_select, pll_enable;
  logic        sub_osc_high_drive, cpu_clk_tick, cpu_run, periph_clk_run;
  logic        sub_periph_clk_run, wait_state_on, recovery_irq;
  int          n_fail, compares, n, m;

  clock_power_mode_control clock_power_mode_control_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_n(nmi_n), .any_write(any_write), .main_clk_run(main_clk_run),
    .sub_clk_select(sub_clk_select), .pll_clk_select(pll_clk_select),
    .pll_enable(pll_enable), .sub_osc_high_drive(sub_osc_high_drive),
    .cpu_clk_tick(cpu_clk_tick), .cpu_run(cpu_run), .periph_clk_run(periph_clk_run),
    .sub_periph_clk_run(sub_periph_clk_run), .wait_state_on(wait_state_on),
    .recovery_irq(recovery_irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data is taken at the edge that samples pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int k;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for: 0 cpu stopped, 1 cpu running, 2 recovery pulse, 3 cpu tick
  task automatic wait_on(input int k, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
      s = (k == 0) ? !cpu_run : (k == 1) ? cpu_run : (k == 2) ? recovery_irq : cpu_clk_tick;
    end while (s !== 1'b1 && cnt < 40);
    if (cnt >= 40) begin
      n_fail++;
      close_out();
    end
  endtask : wait_on

  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_regs;
    chk("main run", main_clk_run, 1);
    chk("periph run", periph_clk_run, 1);
    chk("pll on", pll_enable, 0);
    apb(0, dvr, 0);
    chk("divider reset", rd, 32'h08);
    apb(1, 8'h20, 32'hff);
    apb(0, 8'h20, 0);
    chk("unmapped", rd, 0);
    chk("slverr", pslverr, 0);
    apb(1, cca, 32'h88);
    settle();
    chk("sub select", sub_clk_select, 1);
    chk("sub drive", sub_osc_high_drive, 1);
    apb(1, pmb, 32'h04);
    settle();
    chk("wait state", wait_state_on, 1);
    apb(1, pmb, 0);
    apb(1, ccb, 32'h80);
    settle();
    chk("pll select", pll_clk_select, 1);
    apb(1, ccc, 32'h02);
    settle();
    chk("pll select src", pll_clk_select, 0);
    apb(1, ccc, 0);
    apb(1, ccb, 0);
    apb(1, cca, 0);
  endtask : t_reset_and_regs

  task automatic t_divider;
    logic [4:0] d [3] = '{5'h03, 5'h01, 5'h00};
    foreach (d[i]) begin
      apb(1, dvr, {27'h0, d[i]});
      wait_on(3, n);
      wait_on(3, n);
      wait_on(3, n);
      chk("tick period", n, (d[i] == 0) ? 16 : d[i]);
    end
    apb(1, dvr, 32'h08);
  endtask : t_divider

  task automatic t_guard;
    apb(1, plr, 32'h80);
    apb(0, plr, 0);
    chk("pll guarded", rd, 0);
    apb(1, grd, 32'h04);
    apb(0, grd, 0);
    chk("guard set", rd, 32'h04);
    @(posedge clk_sys);
    any_write <= 1'b1;
    @(posedge clk_sys);
    any_write <= 1'b0;
    apb(0, grd, 0);
    chk("guard cleared by cpu write", rd, 0);
    apb(1, grd, 32'h04);
    apb(1, plr, 32'h80);
    settle();
    chk("pll enabled", pll_enable, 1);
    apb(0, grd, 0);
    chk("guard cleared by bus write", rd, 0);
    apb(1, grd, 32'h04);
    apb(1, plr, 0);
  endtask : t_guard

  task automatic t_stop;
    apb(1, ccb, 32'h01);
    repeat (4) begin
      settle();
      chk("stop refused", cpu_run, 1);
    end
    @(posedge clk_sys);
    nmi_n <= 1'b1;
    apb(1, ccb, 32'h01);
    wait_on(0, n);
    chk("drive high", sub_osc_high_drive, 1);
    chk("main stopped", main_clk_run, 0);
    chk("sub periph stopped", sub_periph_clk_run, 0);
    @(posedge clk_sys);
    nmi_n <= 1'b0;
    wait_on(1, n);
    chk("queue before irq", recovery_irq, 0);
    wait_on(2, m);
    chk("drain length", n + m, 1 + int'(clk_pwr_pkg::prefetch_drain_cycles));
    chk("main back", main_clk_run, 1);
    @(posedge clk_sys);
    nmi_n <= 1'b1;
    apb(1, ccb, 32'h01);
    wait_on(0, n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    chk("reset exit run", cpu_run, 1);
    chk("reset exit main", main_clk_run, 1);
    chk("reset exit drive", sub_osc_high_drive, 0);
  endtask : t_stop

  task automatic t_wait;
    for (int g = 0; g < 2; g++) begin
      apb(1, dvr, (g == 1) ? 32'h14 : 32'h08);
      apb(1, cca, (g == 1) ? 32'h04 : 32'h00);
      apb(1, pmb, 32'h80);
      wait_on(0, n);
      settle();
      chk("periph clock", periph_clk_run, (g == 1) ? 0 : 1);
      chk("sub periph clock", sub_periph_clk_run, 1);
      apb(0, clk_pwr_pkg::mode_status_reg_off, 0);
      chk("wait status", rd, (g == 1) ? 32'h0d : 32'h09);
      @(posedge clk_sys);
      nmi_n <= 1'b0;
      wait_on(2, n);
      chk("wake delay", n, 1);
      @(posedge clk_sys);
      nmi_n <= 1'b1;
      settle();
      chk("periph resumed", periph_clk_run, 1);
    end
  endtask : t_wait

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nmi_n = 1'b0;
    any_write = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    t_reset_and_regs();
    t_divider();
    t_guard();
    t_stop();
    t_wait();
    close_out();
  end
endmodule : test_clock_power_mode_control

bind clock_power_mode_control clock_power_mode_control_sva clock_power_mode_control_sva_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .nmi_n(nmi_n),
  .main_clk_run(main_clk_run), .pll_enable(pll_enable),
  .sub_osc_high_drive(sub_osc_high_drive), .cpu_run(cpu_run),
  .periph_clk_run(periph_clk_run), .sub_periph_clk_run(sub_periph_clk_run),
  .recovery_irq(recovery_irq));
